// ### core/mmn_pkg.sv
// Purpose: constants and types for the move/multiply/negate slice
// Assumes: AXI4-Lite, 32-bit data, byte addresses on awaddr/araddr
// Notes: data space is 4096 bytes, banks of 256
//
// Overview of operation
// - Store copies the accumulator to the addressed file byte, flags untouched, opcode 0110 111a ffff ffff.
// - Store, multiply-by-file and negate reach any of the 256 bytes of the addressed bank via the 8-bit field.
// - Bank-access bit zero uses the access bank, one uses the bank pointer to pick the bank.
// - With the extended set on and the bank-access bit zero, addresses up to 5Fh use indexed literal offset mode.
// - Multiply-by-literal is unsigned accumulator times 8-bit literal, accumulator unchanged.
// - The 16-bit product goes high byte to product high, low byte to product low.
// - Neither multiply touches any status flag.
// - Multiply-by-file is unsigned accumulator times file byte, operands unchanged, bank-access bit honoured.
// - Negate writes back the two's complement and sets N, OV, C, DC and Z from it.
package mmn_pkg;
	// ******************************************
	// Register map (byte offsets)
	// ******************************************
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC   = 8'h04;
	localparam logic [7:0] OFS_BANK  = 8'h08;
	localparam logic [7:0] OFS_PROD  = 8'h0C;
	localparam logic [7:0] OFS_STAT  = 8'h10;
	localparam logic [7:0] OFS_CTRL  = 8'h14;
	localparam logic [7:0] OFS_BASE  = 8'h18;
	localparam logic [7:0] OFS_MADR  = 8'h1C;
	localparam logic [7:0] OFS_MDAT  = 8'h20;
	// ******************************************
	// Status bit positions and reset values
	// ******************************************
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam int ST_OV = 3;
	localparam int ST_N  = 4;
	localparam logic [4:0]  RST_STAT = 5'h00;
	localparam logic [7:0]  RST_ACC  = 8'h00;
	localparam logic [3:0]  RST_BANK = 4'h0;
	localparam logic [11:0] RST_BASE = 12'h000;
	localparam logic [7:0]  ACC_SPLIT = 8'h5F; // Access/indexed split
	localparam logic [3:0]  SFR_PAGE  = 4'hF;
	localparam logic [1:0]  RESP_OK  = 2'b00;
	localparam logic [1:0]  RESP_ERR = 2'b10;
	typedef enum logic [2:0] {
		OP_IDLE, OP_LOADLIT, OP_STORE, OP_MULLIT,
		OP_MULFILE, OP_NEGATE, OP_OTHER
	} op_e;
endpackage

// ### core/mmn_core.sv
// Purpose: executes literal load, store, multiplies, negate, idle
// Assumes: one instruction per write to the instruction register
// Notes: data space held locally as a 4096-byte array
`timescale 1ns/1ps
`default_nettype none
module move_multiply_negate_ops
	import mmn_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready
);
	// ******************************************
	// State
	// ******************************************
	logic [7:0]  mem [0:4095];
	logic [7:0]  acc_r, prod_hi_r, prod_lo_r;
	logic [3:0]  bank_r;
	logic [4:0]  stat_r;
	logic        ext_r;
	logic [11:0] base_r, madr_r;
	logic [7:0]  aw_a_r;
	logic [31:0] w_d_r;
	logic [3:0]  w_s_r;
	logic        aw_full_r, w_full_r;
	logic        aw_full_nxt, w_full_nxt, do_wr, wr_ok;
	logic        exec;
	op_e         op;
	logic [15:0] ins;
	logic [7:0]  fv, lit, neg, mul_b;
	logic [11:0] ea;
	logic [15:0] prod;
	logic [8:0]  nsum;
	logic [4:0]  nlo;
	logic        mem_we;
	logic [7:0]  mem_wd;
	logic [11:0] mem_wa;

	// ******************************************
	// Write channel capture
	// ******************************************
	// Either channel may arrive first; both must be held
	always_comb begin
		do_wr = aw_full_r && w_full_r && !bvalid;
		aw_full_nxt = do_wr ? 1'b0 : (aw_full_r || (awvalid && awready));
		w_full_nxt = do_wr ? 1'b0 : (w_full_r || (wvalid && wready));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_a_r <= 8'h00;
			w_d_r <= 32'h0000_0000;
			w_s_r <= 4'h0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awready <= !aw_full_nxt;
			wready <= !w_full_nxt;
			if (awvalid && awready) aw_a_r <= awaddr;
			if (wvalid && wready) begin
				w_d_r <= wdata;
				w_s_r <= wstrb;
			end
		end
	end

	// Response one cycle after both halves held
	always_comb begin
		case (aw_a_r)
			OFS_INSTR, OFS_ACC, OFS_BANK, OFS_PROD, OFS_STAT,
			OFS_CTRL, OFS_BASE, OFS_MADR, OFS_MDAT: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OK;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? RESP_OK : RESP_ERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ******************************************
	// Decode and datapath
	// ******************************************
	assign exec = do_wr && aw_a_r == OFS_INSTR && w_s_r[1:0] == 2'b11;
	assign ins = w_d_r[15:0];
	assign lit = ins[7:0];

	// Opcode classes
	always_comb begin
		if (ins[15:12] == 4'hF || ins == 16'h0000) op = OP_IDLE;
		else if (ins[15:8] == 8'h0E) op = OP_LOADLIT;
		else if (ins[15:9] == 7'b0110111) op = OP_STORE;
		else if (ins[15:8] == 8'h0D) op = OP_MULLIT;
		else if (ins[15:9] == 7'b0000001) op = OP_MULFILE;
		else if (ins[15:9] == 7'b0110110) op = OP_NEGATE;
		else op = OP_OTHER;
	end

	// Effective file address
	always_comb begin
		if (ins[8]) ea = {bank_r, lit};
		else if (ext_r && lit <= ACC_SPLIT) ea = base_r + {4'h0, lit};
		else if (lit <= ACC_SPLIT) ea = {4'h0, lit};
		else ea = {SFR_PAGE, lit};
	end

	assign fv = mem[ea];
	// Multiplier operand, literal or file byte
	assign mul_b = (op == OP_MULLIT) ? lit : fv;
	// Unsigned product, both sides widened first
	assign prod = {8'h00, acc_r} * {8'h00, mul_b};
	// Two's complement as inverse plus one
	assign nsum = {1'b0, ~fv} + 9'h001;
	assign nlo = {1'b0, ~fv[3:0]} + 5'h01;
	assign neg = nsum[7:0];

	// Memory write port mux
	always_comb begin
		mem_we = 1'b0;
		mem_wa = ea;
		mem_wd = acc_r;
		if (exec && op == OP_STORE) begin
			mem_we = 1'b1;
		end else if (exec && op == OP_NEGATE) begin
			mem_we = 1'b1;
			mem_wd = neg;
		end else if (do_wr && aw_a_r == OFS_MDAT && w_s_r[0]) begin
			mem_we = 1'b1;
			mem_wa = madr_r;
			mem_wd = w_d_r[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (mem_we) mem[mem_wa] <= mem_wd;
	end

	// Accumulator
	always_ff @(posedge aclk) begin
		if (!aresetn) acc_r <= RST_ACC;
		else if (exec && op == OP_LOADLIT) acc_r <= lit;
		else if (do_wr && aw_a_r == OFS_ACC && w_s_r[0]) acc_r <= w_d_r[7:0];
	end

	// Product pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prod_hi_r <= 8'h00;
			prod_lo_r <= 8'h00;
		end else if (exec && (op == OP_MULLIT || op == OP_MULFILE)) begin
			prod_hi_r <= prod[15:8];
			prod_lo_r <= prod[7:0];
		end
	end

	// Status flags, only negate and a status register write change them
	always_ff @(posedge aclk) begin
		if (!aresetn) stat_r <= RST_STAT;
		else if (exec && op == OP_NEGATE) begin
			stat_r[ST_C] <= nsum[8];
			stat_r[ST_DC] <= nlo[4];
			stat_r[ST_Z] <= neg == 8'h00;
			stat_r[ST_OV] <= fv[7] && neg[7]; // Only 80h stays negative when negated
			stat_r[ST_N] <= neg[7];
		end else if (do_wr && aw_a_r == OFS_STAT && w_s_r[0]) stat_r <= w_d_r[4:0];
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_r <= RST_BANK;
			ext_r <= 1'b0;
			base_r <= RST_BASE;
			madr_r <= 12'h000;
		end else if (do_wr && w_s_r[0]) begin
			case (aw_a_r)
				OFS_BANK: bank_r <= w_d_r[3:0];
				OFS_CTRL: ext_r <= w_d_r[0];
				OFS_BASE: base_r <= w_d_r[11:0];
				OFS_MADR: madr_r <= {w_d_r[11:8] & {4{w_s_r[1]}}, w_d_r[7:0]};
				default: ;
			endcase
		end
	end

	// ******************************************
	// Read channel
	// ******************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OK;
			case (araddr)
				OFS_INSTR: rdata <= 32'h0000_0000;
				OFS_ACC: rdata <= {24'h0, acc_r};
				OFS_BANK: rdata <= {28'h0, bank_r};
				OFS_PROD: rdata <= {16'h0, prod_hi_r, prod_lo_r};
				OFS_STAT: rdata <= {27'h0, stat_r};
				OFS_CTRL: rdata <= {31'h0, ext_r};
				OFS_BASE: rdata <= {20'h0, base_r};
				OFS_MADR: rdata <= {20'h0, madr_r};
				OFS_MDAT: rdata <= {24'h0, mem[madr_r]};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= RESP_ERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// ******************************************
	// Checks
	// ******************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Store and addressing
	AST_STORE: assert property (exec && op == OP_STORE |-> mem_we && mem_wd == acc_r && mem_wa == ea)
		else $error("store does not write accumulator");
	AST_BANKED: assert property (exec && ins[8] && op != OP_IDLE |-> ea == {bank_r, lit})
		else $error("banked address wrong");
	AST_ACCESS: assert property (exec && !ins[8] && !ext_r |-> ea[11:8] == (lit > ACC_SPLIT ? SFR_PAGE : 4'h0))
		else $error("access bank address wrong");
	AST_INDEXED: assert property (exec && !ins[8] && ext_r && lit <= ACC_SPLIT |-> ea == base_r + {4'h0, lit})
		else $error("indexed address wrong");
	AST_EXTHIGH: assert property (exec && !ins[8] && ext_r && lit > ACC_SPLIT |-> ea == {SFR_PAGE, lit})
		else $error("upper access bank wrong in extended mode");
	AST_STOREKEEP: assert property (exec && op == OP_STORE |=> acc_r == $past(acc_r))
		else $error("store changed accumulator");

	// Multiplies
	AST_MULLIT: assert property (exec && op == OP_MULLIT |=> {prod_hi_r, prod_lo_r} == $past(acc_r) * $past(lit) && acc_r == $past(acc_r))
		else $error("literal product wrong");
	AST_PRODHI: assert property (exec && op == OP_MULFILE |=> prod_hi_r == $past(prod[15:8]) && prod_lo_r == $past(prod[7:0]))
		else $error("product bytes misplaced");
	AST_MULFLAGS: assert property (exec && (op == OP_MULLIT || op == OP_MULFILE || op == OP_STORE) |=> stat_r == $past(stat_r))
		else $error("multiply changed flags");
	AST_MULFILE: assert property (exec && op == OP_MULFILE |-> !mem_we ##1 {prod_hi_r, prod_lo_r} == $past(acc_r) * $past(fv))
		else $error("file product wrong");
	AST_MULKEEP: assert property (exec && (op == OP_MULLIT || op == OP_MULFILE) |-> !mem_we ##1 acc_r == $past(acc_r))
		else $error("multiply changed an operand");

	// Negate, load and idle
	AST_NEG: assert property (exec && op == OP_NEGATE |=> stat_r[ST_Z] == ($past(fv) == 8'h00) && stat_r[ST_C] == ($past(fv) == 8'h00) && stat_r[ST_OV] == ($past(fv) == 8'h80))
		else $error("negate flags wrong");
	AST_NEGVAL: assert property (exec && op == OP_NEGATE |-> mem_we && mem_wa == ea && mem_wd == (8'h00 - fv))
		else $error("negate result wrong");
	AST_NEGND: assert property (exec && op == OP_NEGATE |=> stat_r[ST_N] == ($past(fv) != 8'h00 && $past(fv) <= 8'h80) && stat_r[ST_DC] == ($past(fv[3:0]) == 4'h0))
		else $error("negate N or DC wrong");
	AST_NEGKEEP: assert property (exec && op == OP_NEGATE |=> acc_r == $past(acc_r))
		else $error("negate changed accumulator");
	AST_LOADNOMEM: assert property (exec && op == OP_LOADLIT |-> !mem_we)
		else $error("literal load wrote a file byte");
	AST_LOADLIT: assert property (exec && op == OP_LOADLIT |=> acc_r == $past(lit) && stat_r == $past(stat_r))
		else $error("literal load wrong");
	AST_IDLE: assert property (exec && op == OP_IDLE |-> !mem_we ##1 acc_r == $past(acc_r) && stat_r == $past(stat_r))
		else $error("idle word changed state");
	AST_IDLEPROD: assert property (exec && op == OP_IDLE |=> {prod_hi_r, prod_lo_r} == $past({prod_hi_r, prod_lo_r}))
		else $error("idle word changed product");

	// Main scenarios
	COV_NEG: cover property (exec && op == OP_NEGATE);
	COV_MUL: cover property (exec && op == OP_MULLIT ##[1:20] exec && op == OP_MULFILE);
	COV_IDLEF: cover property (exec && op == OP_IDLE && ins[15:12] == 4'hF);
	COV_ACCHI: cover property (exec && op == OP_MULFILE && !ins[8] && lit > ACC_SPLIT);
	COV_IDX: cover property (exec && op == OP_STORE && ext_r && !ins[8] && lit <= ACC_SPLIT);
endmodule
`default_nettype wire

// ### bench/tb_move_multiply_negate_ops.sv
// Purpose: self-checking bench for the move/multiply/negate slice
// Assumes: AXI4-Lite map from mmn_pkg, bready and rready held high
// Notes: file bytes are reached through the memory address/data pair
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_move_multiply_negate_ops
	import mmn_pkg::*;
;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	int          mismatches;
	int          cmp_count;
	logic [7:0]  neg_in  [5] = '{8'h3A, 8'h00, 8'h80, 8'h01, 8'h10};
	logic [7:0]  neg_out [5] = '{8'hC6, 8'h00, 8'h80, 8'hFF, 8'hF0};
	logic [31:0] neg_st  [5] = '{32'h10, 32'h07, 32'h1A, 32'h10, 32'h12};
	logic [15:0] idle_w  [3] = '{16'h0000, 16'hF123, 16'hFFFF};
	logic [31:0] v;

	move_multiply_negate_ops u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ****************************************
	// Clock and closing report
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic final_report();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Bounds every wait on the bus
	task automatic guard(inout int n);
		n++;
		if (n > 50) begin
			mismatches++;
			$display("mismatch at %0t: no answer", $time);
			final_report();
		end
	endtask

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
		logic aw_ok;
		logic w_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		n = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			guard(n);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			guard(n);
		end while (bvalid !== 1'b1);
		`CMP(bresp, er)
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OK);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			guard(n);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			guard(n);
		end while (rvalid !== 1'b1);
		d = rdata;
		`CMP(rresp, er)
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] got;
		rd(a, got);
		`CMP(got, e)
	endtask

	task automatic exec(input logic [15:0] w);
		wr(OFS_INSTR, {16'h0000, w});
	endtask

	task automatic poke(input logic [11:0] f, input logic [7:0] b);
		wr(OFS_MADR, {20'h00000, f});
		wr(OFS_MDAT, {24'h000000, b});
	endtask

	task automatic chk_mem(input logic [11:0] f, input logic [7:0] b);
		wr(OFS_MADR, {20'h00000, f});
		chk_reg(OFS_MDAT, {24'h000000, b});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{aresetn, awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
		bready = 1'b1;
		rready = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_reg(OFS_STAT, 32'h00000000);
		chk_reg(OFS_PROD, 32'h00000000);
		wr(OFS_STAT, 32'h00000015);
		exec(16'h0E5A);
		chk_reg(OFS_ACC, 32'h0000005A);
		chk_reg(OFS_STAT, 32'h00000015);
		wr(OFS_BANK, 32'h00000003);
		exec(16'h6F40);
		chk_mem(12'h340, 8'h5A);
		exec(16'h6FFF);
		chk_mem(12'h3FF, 8'h5A);
		exec(16'h6E10);
		chk_mem(12'h010, 8'h5A);
		exec(16'h6E80);
		chk_mem(12'hF80, 8'h5A);
		chk_reg(OFS_STAT, 32'h00000015);
		// Indexed mode edges and the mode switched back off
		wr(OFS_CTRL, 32'h00000001);
		wr(OFS_BASE, 32'h00000200);
		exec(16'h0E77);
		exec(16'h6E05);
		chk_mem(12'h205, 8'h77);
		exec(16'h6E5F);
		chk_mem(12'h25F, 8'h77);
		exec(16'h6E60);
		chk_mem(12'hF60, 8'h77);
		wr(OFS_CTRL, 32'h00000000);
		exec(16'h6E05);
		chk_mem(12'h005, 8'h77);
		// Multiplies, zero and full-scale products
		exec(16'h0EE2);
		exec(16'h0DC4);
		chk_reg(OFS_PROD, 32'h0000AD08);
		chk_reg(OFS_ACC, 32'h000000E2);
		exec(16'h0D00);
		chk_reg(OFS_PROD, 32'h00000000);
		chk_reg(OFS_STAT, 32'h00000015);
		exec(16'h0EFF);
		exec(16'h0DFF);
		chk_reg(OFS_PROD, 32'h0000FE01);
		poke(12'h322, 8'hB5);
		exec(16'h0EC4);
		exec(16'h0322);
		chk_reg(OFS_PROD, 32'h00008A94);
		chk_reg(OFS_ACC, 32'h000000C4);
		chk_mem(12'h322, 8'hB5);
		poke(12'hFF0, 8'h02);
		exec(16'h02F0);
		chk_reg(OFS_PROD, 32'h00000188);
		chk_reg(OFS_STAT, 32'h00000015);
		// Negate across flag corner values
		for (int i = 0; i < 5; i++) begin
			poke(12'h3A0 + 12'(i), neg_in[i]);
			exec(16'h6DA0 + 16'(i));
			chk_mem(12'h3A0 + 12'(i), neg_out[i]);
			chk_reg(OFS_STAT, neg_st[i]);
		end
		// Idle words leave everything alone
		wr(OFS_STAT, 32'h0000000A);
		for (int i = 0; i < 3; i++) begin
			exec(idle_w[i]);
			chk_reg(OFS_ACC, 32'h000000C4);
			chk_reg(OFS_STAT, 32'h0000000A);
			chk_reg(OFS_PROD, 32'h00000188);
		end
		// Unmapped offset answers with an error
		wr(8'h24, 32'h00000055, RESP_ERR);
		rd(8'h24, v, RESP_ERR);
		`CMP(v, 32'h00000000)
		final_report();
	end
endmodule
`default_nettype wire
